// ### hw/dmhcr_fail_out.sv
/*
 Fail output combiner: drives the fail output from the failure flag or from the software
 request bit, the latter only when the shared pin is set up as the fail output.
 Assumes the failure flag is cleared by the host through its own register.
*/
`timescale 1ns/100ps
`default_nettype none

module dmhcr_fail_out
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Sources
   input wire logic fail_output_software_on,
   input wire logic failure_flag,
   input wire logic shared_pin_is_fail,
   // Output
   output logic fail_output
);

   logic fail_ff;
   logic nxt_fail;

   // Software request counts only on a fail-configured pin; failure flag always counts
   always_comb
   begin
      nxt_fail = failure_flag | (fail_output_software_on & shared_pin_is_fail); // [R16] [R17]
   end

   // Output register
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         fail_ff <= 1'b0;
      end
      else
      begin
         fail_ff <= nxt_fail;
      end
   end

   assign fail_output = fail_ff;

endmodule : dmhcr_fail_out

`default_nettype wire

// ### hw/dmhcr_pkg.sv
/*
 Package for the device mode and hardware control register pair: offsets, field positions,
 reset and keep masks, mode encodings and the register access struct.
 Assumes a serial frame decoder elsewhere delivers decoded word accesses.
*/
package dmhcr_pkg;

   // Register word addresses (wordwise addressing)
   localparam logic [6:0] MODE_SUPPLY_CONTROL_ADDR = 7'h01;
   localparam logic [6:0] HARDWARE_CONTROL_ADDR = 7'h02;

   // Mode and supply control field positions
   localparam int MODE_LSB = 14;
   localparam int OVREACT_LSB = 9;
   localparam int HYST_BIT = 7;
   localparam int PEAK_BIT = 5;
   localparam int RTH_LSB = 0;

   // Hardware control field positions
   localparam int THERM_BIT = 12;
   localparam int BATOV_BIT = 11;
   localparam int SHOFF_BIT = 10;
   localparam int RDEL_BIT = 9;
   localparam int SRSUP_BIT = 6;
   localparam int FOSW_BIT = 5;
   localparam int WDSTOP_BIT = 2;

   // Implemented bit masks; all other positions are reserved and read zero
   localparam logic [15:0] MSC_IMPL_MASK = 16'hC6A3;
   localparam logic [15:0] HWC_IMPL_MASK = 16'h1E64;

   // Reset values and bits kept across each reset kind
   localparam logic [15:0] MSC_RESET_VALUE = 16'h0000;
   localparam logic [15:0] HWC_RESET_VALUE = 16'h0000;
   // Restart keeps hysteresis, peak threshold and reset threshold bits only
   localparam logic [15:0] MSC_KEEP_RESTART = 16'h00A3;
   localparam logic [15:0] HWC_KEEP_SOFT = 16'h0200;
   localparam logic [15:0] HWC_KEEP_RESTART = 16'h1240;

   // Soft reset pulse length on the reset output, in cycles
   localparam int SOFT_RESET_PULSE_CYCLES = 4;

   // Device mode encodings
   typedef enum logic [1:0] {
      DMHCR_MODE_NORMAL = 2'b00,
      DMHCR_MODE_SLEEP = 2'b01,
      DMHCR_MODE_STOP = 2'b10,
      DMHCR_MODE_SOFTRST = 2'b11
   } dmhcr_mode_type;

   // Over-voltage reaction encodings
   typedef enum logic [1:0] {
      DMHCR_OV_NONE = 2'b00,
      DMHCR_OV_INTERRUPT = 2'b01,
      DMHCR_OV_RESET = 2'b10,
      DMHCR_OV_FAILSAFE = 2'b11
   } dmhcr_ovreact_type;

   // One decoded register access from the serial frame decoder
   typedef struct packed {
      logic valid;
      logic write;
      logic [6:0] addr;
      logic [15:0] wdata;
   } dmhcr_access_type;

   // Decoded configuration seen by the rest of the chip
   typedef struct packed {
      dmhcr_mode_type mode;
      dmhcr_ovreact_type supply_overvolt_reaction;
      logic undervolt_release_hysteresis;
      logic regulator_peak_threshold;
      logic [1:0] undervolt_reset_threshold;
      logic thermal_release_wait_select;
      logic battery_overvolt_threshold_select;
      logic sample_hold_off;
      logic reset_delay_select;
      logic soft_reset_pin_suppress;
      logic watchdog_stop_disable_hi;
   } dmhcr_config_type;

endpackage : dmhcr_pkg

// ### hw/dmhcr_regs.sv
/*
 Mode and supply control plus hardware control register pair, with reset kinds, hardware
 updates of mode and stop-mode watchdog bits, and soft reset pin pulse.
 Assumes a frame decoder delivers one access at a time and samples rdata on the next cycle.
*/
// Operation
// [R1] Mode field selects normal, sleep, stop, soft reset
// [R2] Stop to sleep write is refused
// [R3] Restart forces mode field to normal
// [R4] Write returns previously written register value
// [R5] Bits 10:9 select over-voltage reaction
// [R6] Bit 7 selects highest release threshold
// [R7] Bit 5 selects regulator peak threshold
// [R8] Bits 1:0 select reset threshold
// [R9] Reserved bits always read zero
// [R10] Mode register reset and restart keep values
// [R11] Bit 12 selects thermal release wait
// [R12] Bit 11 selects battery over-voltage threshold
// [R13] Bit 10 disables sample and hold
// [R14] Bit 9 selects 10 ms or 2 ms
// [R15] Bit 6 suppresses reset pin on soft reset
// [R16] Bit 5 drives fail output if pin configured
// [R17] Host clears failure flag to release output
// [R18] Restart clears software fail bit
// [R19] Stop to normal clears watchdog stop bit
// [R20] Hardware register reset and restart keep values
// [R21] Host reads with command bit clear
// [R22] Host writes reserved bits as zero
// [R23] Reserved bit writes have no effect
// [R24] Hardware update beats concurrent register write
`timescale 1ns/100ps
`default_nettype none

module dmhcr_regs
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register access from frame decoder
   input wire dmhcr_pkg::dmhcr_access_type access,
   output logic [15:0] rdata,
   output logic rdata_hit,
   // Device events
   input wire logic restart_enter,
   input wire logic stop_to_normal,
   input wire logic failure_flag,
   input wire logic shared_pin_is_fail,
   // Decoded configuration and pins
   output dmhcr_pkg::dmhcr_config_type config_out,
   output logic soft_reset_request,
   output logic reset_output_pin_n,
   output logic fail_output
);

   logic [15:0] msc_ff;
   logic [15:0] nxt_msc;
   logic [15:0] hwc_ff;
   logic [15:0] nxt_hwc;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic hit_ff;
   logic nxt_hit;
   logic srst_ff;
   logic nxt_srst;
   logic [2:0] pulse_ff;
   logic [2:0] nxt_pulse;
   logic msc_wr;
   logic hwc_wr;
   logic [1:0] wr_mode;
   logic [15:0] msc_wdata;

   // Address decode of the access
   assign msc_wr = access.valid & access.write
                 & (access.addr == dmhcr_pkg::MODE_SUPPLY_CONTROL_ADDR);
   assign hwc_wr = access.valid & access.write
                 & (access.addr == dmhcr_pkg::HARDWARE_CONTROL_ADDR);
   assign wr_mode = access.wdata[dmhcr_pkg::MODE_LSB +: 2];

   // Next value of the mode and supply control register
   always_comb
   begin
      msc_wdata = access.wdata & dmhcr_pkg::MSC_IMPL_MASK; // [R23]
      nxt_msc = msc_ff;
      nxt_srst = 1'b0;
      if (msc_wr)
      begin
         if ((msc_ff[dmhcr_pkg::MODE_LSB +: 2] == dmhcr_pkg::DMHCR_MODE_STOP)
             && (wr_mode == dmhcr_pkg::DMHCR_MODE_SLEEP))
         begin
            // Mode kept, other fields still taken
            msc_wdata[dmhcr_pkg::MODE_LSB +: 2] = msc_ff[dmhcr_pkg::MODE_LSB +: 2]; // [R2]
         end
         nxt_msc = msc_wdata; // [R1] [R5] [R6] [R7] [R8]
         nxt_srst = (wr_mode == dmhcr_pkg::DMHCR_MODE_SOFTRST)
                  && !((msc_ff[dmhcr_pkg::MODE_LSB +: 2] == dmhcr_pkg::DMHCR_MODE_STOP)
                       && 1'b0); // [R1]
      end
      if (restart_enter)
      begin
         // Hardware update wins over a write in the same cycle
         nxt_msc = msc_ff & dmhcr_pkg::MSC_KEEP_RESTART; // [R10] [R3] [R24]
      end
      if (srst_ff)
      begin
         nxt_msc = dmhcr_pkg::MSC_RESET_VALUE; // [R10]
      end
   end

   // Next value of the hardware control register
   always_comb
   begin
      nxt_hwc = hwc_ff;
      if (hwc_wr)
      begin
         nxt_hwc = access.wdata & dmhcr_pkg::HWC_IMPL_MASK; // [R23] [R11] [R12] [R13] [R14]
      end
      if (stop_to_normal)
      begin
         nxt_hwc[dmhcr_pkg::WDSTOP_BIT] = 1'b0; // [R19] [R24]
      end
      if (restart_enter)
      begin
         nxt_hwc = hwc_ff & dmhcr_pkg::HWC_KEEP_RESTART; // [R20] [R18] [R24]
      end
      if (srst_ff)
      begin
         nxt_hwc = hwc_ff & dmhcr_pkg::HWC_KEEP_SOFT; // [R20]
      end
   end

   // Read data: a write returns the value held before it, reserved bits zero
   always_comb
   begin
      nxt_rdata = 16'h0000;
      nxt_hit = 1'b0;
      if (access.valid)
      begin
         if (access.addr == dmhcr_pkg::MODE_SUPPLY_CONTROL_ADDR)
         begin
            nxt_rdata = msc_ff & dmhcr_pkg::MSC_IMPL_MASK; // [R4] [R9]
            nxt_hit = 1'b1;
         end
         else if (access.addr == dmhcr_pkg::HARDWARE_CONTROL_ADDR)
         begin
            nxt_rdata = hwc_ff & dmhcr_pkg::HWC_IMPL_MASK; // [R9]
            nxt_hit = 1'b1;
         end
      end
   end

   // Reset pin pulse counter: runs only when the soft reset is not suppressed
   always_comb
   begin
      nxt_pulse = (pulse_ff != 3'h0) ? pulse_ff - 3'h1 : 3'h0;
      if (srst_ff && !hwc_ff[dmhcr_pkg::SRSUP_BIT])
      begin
         nxt_pulse = 3'(dmhcr_pkg::SOFT_RESET_PULSE_CYCLES); // [R15]
      end
   end

   // State registers
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         msc_ff <= dmhcr_pkg::MSC_RESET_VALUE;
         hwc_ff <= dmhcr_pkg::HWC_RESET_VALUE;
         rdata_ff <= 16'h0000;
         hit_ff <= 1'b0;
         srst_ff <= 1'b0;
         pulse_ff <= 3'h0;
      end
      else
      begin
         msc_ff <= nxt_msc;
         hwc_ff <= nxt_hwc;
         rdata_ff <= nxt_rdata;
         hit_ff <= nxt_hit;
         srst_ff <= nxt_srst;
         pulse_ff <= nxt_pulse;
      end
   end

   // Outputs
   assign rdata = rdata_ff;
   assign rdata_hit = hit_ff;
   assign soft_reset_request = srst_ff;
   assign reset_output_pin_n = (pulse_ff == 3'h0);

   // Decoded configuration fields
   always_comb
   begin
      config_out.mode = dmhcr_pkg::dmhcr_mode_type'(msc_ff[dmhcr_pkg::MODE_LSB +: 2]);
      config_out.supply_overvolt_reaction =
         dmhcr_pkg::dmhcr_ovreact_type'(msc_ff[dmhcr_pkg::OVREACT_LSB +: 2]); // [R5]
      config_out.undervolt_release_hysteresis = msc_ff[dmhcr_pkg::HYST_BIT]; // [R6]
      config_out.regulator_peak_threshold = msc_ff[dmhcr_pkg::PEAK_BIT]; // [R7]
      config_out.undervolt_reset_threshold = msc_ff[dmhcr_pkg::RTH_LSB +: 2]; // [R8]
      config_out.thermal_release_wait_select = hwc_ff[dmhcr_pkg::THERM_BIT]; // [R11]
      config_out.battery_overvolt_threshold_select = hwc_ff[dmhcr_pkg::BATOV_BIT]; // [R12]
      config_out.sample_hold_off = hwc_ff[dmhcr_pkg::SHOFF_BIT]; // [R13]
      config_out.reset_delay_select = hwc_ff[dmhcr_pkg::RDEL_BIT]; // [R14]
      config_out.soft_reset_pin_suppress = hwc_ff[dmhcr_pkg::SRSUP_BIT]; // [R15]
      config_out.watchdog_stop_disable_hi = hwc_ff[dmhcr_pkg::WDSTOP_BIT];
   end

   // Fail output combiner
   dmhcr_fail_out u_fail_out
   (
      .mclk(mclk),
      .reset(reset),
      .fail_output_software_on(hwc_ff[dmhcr_pkg::FOSW_BIT]), // [R16] [R18]
      .failure_flag(failure_flag),
      .shared_pin_is_fail(shared_pin_is_fail),
      .fail_output(fail_output)
   );

endmodule : dmhcr_regs

`default_nettype wire

// ### verif/dmhcr_host_model.sv
/*
 Host side model: issues decoded word accesses to the register pair.
 Assumes callers enter its tasks just after a falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module dmhcr_host_model
(
   // Access toward the register pair
   output var dmhcr_pkg::dmhcr_access_type access
);
   initial access = '0;
   // One access, held across the following rising edge
   task automatic put(input logic wr, input logic [6:0] a, input logic [15:0] d);
      access = {1'b1, wr, a, d};
   endtask : put
   // Released lines show the inverse of their last value
   task automatic rel();
      access = {1'b0, ~access.write, ~access.addr, ~access.wdata};
   endtask : rel
endmodule : dmhcr_host_model
`default_nettype wire

// ### verif/dmhcr_monitor.sv
/*
 Checker for the register pair: readback, soft reset, restart, stop exit and fail output.
 Assumes it is bound to dmhcr_regs, one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module dmhcr_monitor
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Access and answer
   input wire dmhcr_pkg::dmhcr_access_type access,
   input wire logic [15:0] rdata,
   input wire logic rdata_hit,
   // Device events
   input wire logic restart_enter,
   input wire logic stop_to_normal,
   input wire logic failure_flag,
   input wire logic shared_pin_is_fail,
   // Configuration and pins
   input wire dmhcr_pkg::dmhcr_config_type config_out,
   input wire logic soft_reset_request,
   input wire logic reset_output_pin_n,
   input wire logic fail_output
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // Decoded access kinds
   wire logic hit = access.valid && (access.addr == 7'h01 || access.addr == 7'h02);
   wire logic wr1 = access.valid && access.write && access.addr == 7'h01 && !restart_enter;
   read_hit_a: assert property (1 |=> rdata_hit == $past(hit)) else $error("hit wrong");
   rsvd_zero_a: assert property (access.valid |=>
      (rdata & ~($past(access.addr[1]) ? 16'h1E64 : 16'hC6A3)) == 16'h0000) else $error("rsvd");
   soft_start_a: assert property (wr1 && access.wdata[15:14] == 2'b11 |=> soft_reset_request
      && config_out.mode == dmhcr_pkg::DMHCR_MODE_SOFTRST) else $error("soft start");
   soft_clear_a: assert property (soft_reset_request |=> 14'(config_out) ==
      (14'($past(config_out)) & 14'h0004)) else $error("soft clear");
   pin_pulse_a: assert property (soft_reset_request && !config_out.soft_reset_pin_suppress
      |=> !reset_output_pin_n [*4] ##1 reset_output_pin_n) else $error("pin pulse");
   pin_quiet_a: assert property (soft_reset_request && config_out.soft_reset_pin_suppress
      |=> reset_output_pin_n [*4]) else $error("pin quiet");
   restart_keep_a: assert property (restart_enter && !soft_reset_request |=>
      14'(config_out) == (14'($past(config_out)) & 14'h03E6)) else $error("restart");
   stop_wd_a: assert property (stop_to_normal && !soft_reset_request |=>
      !config_out.watchdog_stop_disable_hi) else $error("stop exit");
   stop_sleep_a: assert property (wr1 && access.wdata[15:14] == 2'b01 && !soft_reset_request
      && config_out.mode == dmhcr_pkg::DMHCR_MODE_STOP |=>
      config_out.mode == dmhcr_pkg::DMHCR_MODE_STOP) else $error("stop to sleep");
   fail_flag_a: assert property (!shared_pin_is_fail |=>
      fail_output == $past(failure_flag)) else $error("fail out");
   // Main scenarios reached
   cover property (soft_reset_request);
   cover property (restart_enter);
   cover property (wr1 && access.wdata[15:14] == 2'b01 && config_out.mode[1]);
endmodule : dmhcr_monitor

bind dmhcr_regs dmhcr_monitor dmhcr_monitor_i (.mclk, .reset, .access, .rdata, .rdata_hit,
   .restart_enter, .stop_to_normal, .failure_flag, .shared_pin_is_fail, .config_out,
   .soft_reset_request, .reset_output_pin_n, .fail_output);
`default_nettype wire

// ### verif/dmhcr_tb_top.sv
/*
 Testbench for the register pair: a word model checks every answer and configuration.
 Assumes a 200 MHz clock and the host model for accesses.
*/
`timescale 1ns/100ps
`default_nettype none

module dmhcr_tb_top;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic restart_enter = 1'b0, stop_to_normal = 1'b0;
   logic failure_flag = 1'b0, shared_pin_is_fail = 1'b0;
   wire dmhcr_pkg::dmhcr_access_type access;
   dmhcr_pkg::dmhcr_config_type config_out;
   logic [15:0] rdata, msc = 16'h0000, hwc = 16'h0000, d;
   logic rdata_hit, soft_reset_request, reset_output_pin_n, fail_output;
   logic [1:0] fs = 2'b00;
   int errors = 0, total_checks = 0, cycles = 0;
   // Clock and hang guard
   always #2.5 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         errors++;
         final_report();
      end
   end
   dmhcr_host_model dmhcr_host_model_i (.access);
   dmhcr_regs dmhcr_regs_i (.mclk, .reset, .access, .rdata, .rdata_hit, .restart_enter,
      .stop_to_normal, .failure_flag, .shared_pin_is_fail, .config_out, .soft_reset_request,
      .reset_output_pin_n, .fail_output);
   // Compare one value
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Compare decoded configuration with the word model
   task automatic cfg();
      chk(16'(config_out), {2'h0, msc[15:14], msc[10:9], msc[7], msc[5], msc[1:0], hwc[12:9],
         hwc[6], hwc[2]});
   endtask : cfg
   // One access with events {restart, stop exit}; answer checked, model updated
   task automatic acc(input logic wr, input logic [6:0] a, input logic [15:0] v,
      input logic [1:0] ev);
      logic [15:0] old;
      logic fexp;
      old = (a == 7'h01) ? msc : (a == 7'h02) ? hwc : 16'h0000;
      @(negedge mclk);
      {restart_enter, stop_to_normal} = ev;
      {failure_flag, shared_pin_is_fail} = fs;
      fexp = failure_flag | (hwc[5] & shared_pin_is_fail);
      dmhcr_host_model_i.put(wr, a, v);
      @(posedge mclk);
      #1;
      chk(rdata, old);
      chk({15'h0, rdata_hit}, {15'h0, a == 7'h01 || a == 7'h02});
      chk({15'h0, fail_output}, {15'h0, fexp});
      if (ev[1])
      begin
         msc = msc & 16'h00A3;
         hwc = hwc & 16'h1240;
      end
      else if (wr && a == 7'h01)
         msc = (msc[15:14] == 2'b10 && v[15:14] == 2'b01) ? {2'b10, v[13:0] & 14'h06A3}
            : v & 16'hC6A3;
      else if (wr && a == 7'h02)
         hwc = v & 16'h1E64;
      if (ev[0])
         hwc[2] = 1'b0;
      cfg();
   endtask : acc
   // Verdict
   task automatic final_report();
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // Main sequence
   initial
   begin
      void'($urandom(32'hDBA7));
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      acc(1'b0, 7'h01, 16'h0000, 2'b00);
      acc(1'b0, 7'h02, 16'h0000, 2'b00);
      acc(1'b1, 7'h03, 16'hFFFF, 2'b00);
      repeat (60)
      begin
         d = $urandom();
         if (d[15:14] == 2'b11)
            d[15] = 1'b0;
         fs = d[7:6];
         acc(d[13] | d[4], d[1] ? 7'h02 : 7'h01, d, {1'b0, d[8] & d[3]});
      end
      fs = 2'b01;
      acc(1'b1, 7'h02, 16'hFFFF, 2'b00);
      acc(1'b1, 7'h01, 16'h86A3, 2'b00);
      acc(1'b1, 7'h01, 16'h4000, 2'b00);
      acc(1'b1, 7'h02, 16'hFFFF, 2'b01);
      acc(1'b0, 7'h02, 16'h0000, 2'b10);
      acc(1'b0, 7'h02, 16'h0000, 2'b00);
      for (int s = 0; s < 2; s++)
      begin
         acc(1'b1, 7'h02, 16'h0200 | 16'(s << 6), 2'b00);
         acc(1'b1, 7'h01, 16'hC000, 2'b00);
         chk({15'h0, soft_reset_request}, 16'h0001);
         msc = 16'h0000;
         hwc = hwc & 16'h0200;
         @(negedge mclk);
         dmhcr_host_model_i.rel();
         for (int c = 0; c < 5; c++)
         begin
            @(posedge mclk);
            #1;
            chk({15'h0, reset_output_pin_n}, {15'h0, s[0] || c == 4});
            cfg();
         end
      end
      final_report();
   end
endmodule : dmhcr_tb_top
`default_nettype wire
